// [switch_host_pkg.sv]
package switch_host_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int SHARED_W = 6;
  localparam int CNT_W = 8;
  localparam int SYS_CLK_KHZ = 125000;
  localparam int SCLK_SLOW_KHZ = 4096;
  localparam int SCLK_FAST_KHZ = 8192;
  // serial clock periods in system clock cycles, rounded down
  localparam int SCLK_SLOW_CYC = SYS_CLK_KHZ / SCLK_SLOW_KHZ;
  localparam int SCLK_FAST_CYC = SYS_CLK_KHZ / SCLK_FAST_KHZ;
  localparam logic [CNT_W-1:0] SCLK_SPLIT_CYC =
    CNT_W'((SCLK_SLOW_CYC + SCLK_FAST_CYC) / 2);
  // a frame pulse lasts less than three slow serial clocks
  localparam logic [CNT_W-1:0] FP_MAX_CYC = CNT_W'(3 * SCLK_SLOW_CYC);
  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
  localparam int ACK_DELAY_NS = 16;
  localparam int CLK_PERIOD_NS = 8;
  localparam logic [1:0] ACK_DELAY_CYC =
    2'((ACK_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [1:0] ACK_CNT_ZERO = 2'h0;
  localparam logic [1:0] ACK_CNT_ONE = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [SHARED_W-1:0] SHARED_ZERO = 6'h00;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_WAIT = 2'b01,
    ACC_DONE = 2'b10
  } acc_state_t;
endpackage

// [edge_detect.sv]
`timescale 1ns/1ps
`default_nettype none
module edge_detect (
  input wire logic clk,
  input wire logic resetn,
  input wire logic level,
  output logic rise,
  output logic fall
);
  logic level_ff;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      level_ff <= 1'h0;
    end else begin
      level_ff <= level;
    end
  end

  assign rise = level & ~level_ff;
  assign fall = ~level & level_ff;
endmodule
`default_nettype wire

// [switch_host_port.sv]
// Summary of operation
// RULE_01 - detect frame pulse format automatically
// RULE_02 - serial clock 4.096 or 8.192 MHz
// RULE_03 - non-multiplexed: shared pins are address 0-2
// RULE_04 - 16x8 mode: shared pins are inputs 8-10
// RULE_05 - non-multiplexed: next pins are address 3-5
// RULE_06 - 16x8 mode: next pins are inputs 11-13
// RULE_07 - data strobe high with select does access
// RULE_08 - drive bus while read strobe low
// RULE_09 - read/write level sets bus direction
// RULE_10 - bus is input while write strobe low; code drives it if read strobe is also low
// RULE_11 - accesses only while chip select low
// RULE_12 - bus reaches registers and memories
// RULE_13 - multiplexed: address taken from bus lines
// RULE_14 - style pin high selects multiplexed bus
// RULE_15 - latch address on strobe falling edge
// RULE_16 - open-drain acknowledge low ends transfer
// RULE_17 - reset clears state, serial outputs float
// RULE_18 - bus floats unless selected and reading
`timescale 1ns/1ps
`default_nettype none
module switch_host_port (
  input wire logic clk,
  input wire logic resetn,
  input wire logic bus_style_pin,
  input wire logic sepStrobeStyle,
  input wire logic chipSelectN,
  input wire logic bus_strobe_or_read_strobe_n,
  input wire logic rwOrWriteN,
  input wire logic address_latch_strobe,
  input wire logic [switch_host_pkg::DATA_W-1:0] hostBusIn,
  output logic [switch_host_pkg::DATA_W-1:0] hostBusOut,
  output logic hostBusOe,
  output logic transfer_ack_n,
  output logic transferAckOe,
  input wire logic [switch_host_pkg::SHARED_W-1:0] sharedPins,
  input wire logic sixteenByEight,
  input wire logic speedFast,
  input wire logic serialClk,
  input wire logic frame_sync_in,
  output logic [switch_host_pkg::SHARED_W-1:0] serialExtraIn,
  output logic [switch_host_pkg::ADDR_W-1:0] regAddr,
  output logic [switch_host_pkg::DATA_W-1:0] regWdata,
  output logic regWrite,
  output logic regRead,
  input wire logic [switch_host_pkg::DATA_W-1:0] regRdata,
  output logic frameStart,
  output logic frameGci,
  output logic clockMismatch,
  output logic serialOutEnable
);
  import switch_host_pkg::*;

  acc_state_t accState_ff, nxt_accState;
  logic [1:0] ackCnt_ff, nxt_ackCnt;
  logic [ADDR_W-1:0] latchAddr_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [ADDR_W-1:0] regAddr_ff;
  logic [DATA_W-1:0] regWdata_ff;
  logic regWrite_ff, regRead_ff;
  logic [CNT_W-1:0] fsCnt_ff, sclkCnt_ff;
  logic frameStart_ff, frameGci_ff, clockMismatch_ff, serialOutEnable_ff;
  logic [SHARED_W-1:0] serialExtra_ff;

  // bus decoding
  wire muxMode = bus_style_pin; // [RULE_14]
  wire sepStrobes = muxMode & sepStrobeStyle;
  wire selected = ~chipSelectN; // [RULE_11]
  wire dataStrobe = bus_strobe_or_read_strobe_n;
  wire sepRead = selected & ~bus_strobe_or_read_strobe_n; // [RULE_08]
  wire sepWrite = selected & ~rwOrWriteN; // [RULE_10]
  wire dsAccess = selected & dataStrobe; // [RULE_07]
  wire dsRead = dsAccess & rwOrWriteN; // [RULE_09]
  wire dsWrite = dsAccess & ~rwOrWriteN; // [RULE_09]
  wire readActive = sepStrobes ? sepRead : dsRead;
  wire writeActive = sepStrobes ? (sepWrite & ~sepRead) : dsWrite;
  wire accessActive = readActive | writeActive;
  wire [ADDR_W-1:0] pinAddr = {2'h0, sharedPins}; // [RULE_03] [RULE_05]
  wire [ADDR_W-1:0] accAddr = muxMode ? latchAddr_ff : pinAddr; // [RULE_13]
  wire accessStart;
  wire aleFall;
  wire fsRise, fsFall;
  wire sclkRise;
  wire ackDone = (ackCnt_ff == ACK_DELAY_CYC - ACK_CNT_ONE);
  wire fsShort = (fsCnt_ff < FP_MAX_CYC);
  wire sclkMeasuredFast = (sclkCnt_ff < SCLK_SPLIT_CYC);

  edge_detect accEdge (
    .clk(clk),
    .resetn(resetn),
    .level(accessActive),
    .rise(accessStart),
    .fall()
  );

  edge_detect aleEdge (
    .clk(clk),
    .resetn(resetn),
    .level(address_latch_strobe),
    .rise(),
    .fall(aleFall)
  );

  edge_detect fsEdge (
    .clk(clk),
    .resetn(resetn),
    .level(frame_sync_in),
    .rise(fsRise),
    .fall(fsFall)
  );

  edge_detect sclkEdge (
    .clk(clk),
    .resetn(resetn),
    .level(serialClk),
    .rise(sclkRise),
    .fall()
  );

  // access sequencing and acknowledge
  always_comb begin
    nxt_accState = accState_ff;
    nxt_ackCnt = ackCnt_ff;
    case (accState_ff)
      ACC_IDLE: begin
        nxt_ackCnt = ACK_CNT_ZERO;
        if (accessStart) begin
          nxt_accState = ACC_WAIT;
        end
      end
      ACC_WAIT: begin
        nxt_ackCnt = ackCnt_ff + ACK_CNT_ONE;
        if (!accessActive) begin
          nxt_accState = ACC_IDLE;
        end else if (ackDone) begin
          nxt_accState = ACC_DONE;
        end
      end
      ACC_DONE: begin
        if (!accessActive) begin
          nxt_accState = ACC_IDLE;
        end
      end
      default: begin
        nxt_accState = ACC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin // [RULE_17]
      accState_ff <= ACC_IDLE;
      ackCnt_ff <= ACK_CNT_ZERO;
    end else begin
      accState_ff <= nxt_accState;
      ackCnt_ff <= nxt_ackCnt;
    end
  end

  // address latch, multiplexed bus only
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      latchAddr_ff <= ADDR_ZERO;
    end else if (muxMode && aleFall) begin
      latchAddr_ff <= hostBusIn; // [RULE_15] [RULE_13]
    end
  end

  // one access pulse per strobe, toward registers and memories
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      regAddr_ff <= ADDR_ZERO;
      regWdata_ff <= DATA_ZERO;
      regWrite_ff <= 1'h0;
      regRead_ff <= 1'h0;
      rdata_ff <= DATA_ZERO;
    end else begin
      regWrite_ff <= accessStart & writeActive; // [RULE_12]
      regRead_ff <= accessStart & readActive; // [RULE_12]
      if (accessStart) begin
        regAddr_ff <= accAddr;
        regWdata_ff <= hostBusIn;
      end
      // memory read data may lag the strobe, so keep sampling until ack
      if (accState_ff == ACC_WAIT) begin
        rdata_ff <= regRdata;
      end
    end
  end

  // frame pulse format: a short high pulse is the GCI style
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fsCnt_ff <= CNT_ZERO;
      frameGci_ff <= 1'h0;
      frameStart_ff <= 1'h0;
    end else begin
      frameStart_ff <= (fsRise | fsFall) & fsShort;
      if (fsRise || fsFall) begin
        fsCnt_ff <= CNT_ZERO;
        if (fsShort) begin
          frameGci_ff <= fsFall; // [RULE_01]
        end
      end else if (fsCnt_ff != CNT_MAX) begin
        fsCnt_ff <= fsCnt_ff + CNT_ONE;
      end
    end
  end

  // serial clock rate check against the selected speed
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclkCnt_ff <= CNT_ZERO;
      clockMismatch_ff <= 1'h0;
    end else if (sclkRise) begin
      sclkCnt_ff <= CNT_ZERO;
      clockMismatch_ff <= sclkMeasuredFast ^ speedFast; // [RULE_02]
    end else if (sclkCnt_ff != CNT_MAX) begin
      sclkCnt_ff <= sclkCnt_ff + CNT_ONE;
    end
  end

  // shared pins as extra 2.048 Mb/s inputs; serial side held off in reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      serialExtra_ff <= SHARED_ZERO;
      serialOutEnable_ff <= 1'h0; // [RULE_17]
    end else begin
      serialExtra_ff <=
        sixteenByEight ? sharedPins : SHARED_ZERO; // [RULE_04] [RULE_06]
      serialOutEnable_ff <= 1'h1;
    end
  end

  assign hostBusOut = rdata_ff;
  assign hostBusOe = readActive; // [RULE_08] [RULE_18]
  assign transfer_ack_n = 1'h0;
  assign transferAckOe = (accState_ff == ACC_DONE); // [RULE_16]
  assign serialExtraIn = serialExtra_ff;
  assign regAddr = regAddr_ff;
  assign regWdata = regWdata_ff;
  assign regWrite = regWrite_ff;
  assign regRead = regRead_ff;
  assign frameStart = frameStart_ff;
  assign frameGci = frameGci_ff;
  assign clockMismatch = clockMismatch_ff;
  assign serialOutEnable = serialOutEnable_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_bus_floats: assert property ( // [RULE_18] [RULE_11]
    chipSelectN |-> !hostBusOe)
    else $error("bus driven without chip select");
  chk_sep_read_drive: assert property ( // [RULE_08]
    sepStrobes && selected && !bus_strobe_or_read_strobe_n |-> hostBusOe)
    else $error("read strobe did not drive bus");
  chk_sep_write_input: assert property ( // [RULE_10]
    sepStrobes && !rwOrWriteN && bus_strobe_or_read_strobe_n |-> !hostBusOe)
    else $error("bus driven during write strobe");
  chk_ds_direction: assert property ( // [RULE_09] [RULE_07]
    !sepStrobes && selected && dataStrobe |-> hostBusOe == rwOrWriteN)
    else $error("bus direction not set by read/write");
  chk_addr_latch: assert property ( // [RULE_15] [RULE_13]
    muxMode && aleFall |=> latchAddr_ff == $past(hostBusIn))
    else $error("address not latched on strobe fall");
  chk_pin_addr: assert property ( // [RULE_03] [RULE_05] [RULE_14]
    !muxMode && accessStart |=> regAddr == $past(pinAddr))
    else $error("pin address not used");
  chk_serial_route: assert property ( // [RULE_04] [RULE_06]
    sixteenByEight |=> serialExtraIn == $past(sharedPins))
    else $error("shared pins not routed to serial inputs");
  chk_ack_timing: assert property ( // [RULE_16]
    accessStart ##1 accessActive[*2] |=> transferAckOe)
    else $error("acknowledge late");
  chk_ack_early: assert property ( // [RULE_16]
    accessStart |=> !transferAckOe ##1 !transferAckOe)
    else $error("acknowledge early");
  chk_ack_release: assert property ( // [RULE_16]
    !accessActive |=> !transferAckOe)
    else $error("acknowledge held after access");
  chk_frame_format: assert property ( // [RULE_01]
    fsShort && fsFall |=> frameGci ##1 frameStart == 1'h0)
    else $error("high frame pulse not seen as GCI");
  chk_clock_rate: assert property ( // [RULE_02]
    sclkRise && sclkMeasuredFast && !speedFast |=> clockMismatch)
    else $error("serial clock rate mismatch missed");
  chk_reset_float: assert property ( // [RULE_17]
    @(posedge clk) disable iff (1'h0)
    !resetn |-> !serialOutEnable && !transferAckOe)
    else $error("serial outputs enabled in reset");

  cov_sep_read: cover property (sepStrobes && accessStart && readActive);
  cov_mux_write: cover property (muxMode && regWrite);
  cov_pin_read: cover property (!muxMode && regRead);
  cov_gci_frame: cover property (frameStart && frameGci);
endmodule
`default_nettype wire

// [host_cpu_model.sv]
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
  input wire logic clk,
  input wire logic ackOe,
  input wire logic devOe,
  input wire logic [7:0] busIn,
  output logic csN,
  output logic strobe,
  output logic rw,
  output logic ale,
  output logic [7:0] drv,
  output logic drvOe,
  output logic [5:0] addrPins
);
  initial begin
    csN = 1'h1;
    strobe = 1'h0;
    rw = 1'h1;
    ale = 1'h0;
    drv = 8'h00;
    drvOe = 1'h0;
    addrPins = 6'h00;
  end
  // holds every request line until the acknowledge is seen at an edge, for at most 8 edges
  task automatic xfer(input logic mux, sep, rd, sel,
    input logic [7:0] a, wd, output logic [7:0] rv, output logic ok, oe);
    int n = 0;
    @(negedge clk);
    addrPins = a[5:0];
    if (mux) begin
      drv = a;
      drvOe = 1'h1;
      ale = 1'h1;
      @(negedge clk);
      ale = 1'h0;
      // address stays on the lines a while after the latch edge
      repeat (2) @(negedge clk);
    end
    drv = wd;
    drvOe = !rd;
    csN = !sel;
    strobe = (mux && sep) ? !rd : 1'h1;
    rw = rd;
    do begin
      @(posedge clk);
      n++;
    end while (!ackOe && n < 8);
    rv = busIn;
    ok = ackOe;
    oe = devOe;
    @(negedge clk);
    csN = 1'h1;
    strobe = mux && sep;
    rw = 1'h1;
    drvOe = 1'h0;
  endtask
endmodule
`default_nettype wire

// [test_switch_host_bus_and_pin_roles.sv]
`timescale 1ns/1ps
`default_nettype none
module test_switch_host_bus_and_pin_roles;
  import switch_host_pkg::*;
  logic clk, resetn, busStyle, sepStyle, csN, strobe, rw, ale, drvOe;
  logic x16, fast, sclk, frame, ackOe, ackN, busOe, regWrite, regRead;
  logic frameStart, frameGci, clockMismatch, serialOutEnable, ok, oe;
  logic [7:0] drv, busIn, busOut, lastBus, regAddr, regWdata, regRdata, rv;
  logic [7:0] lastWa, lastWd, lastRa;
  logic [5:0] addrPins, serialBits, sharedPins, serialExtraIn;
  int errCount = 0;
  int samplesChecked = 0;
  int wrCnt = 0;
  int rdCnt = 0;
  int frames = 0;
  // released lines show the inverse of their last level
  assign busIn = busOe ? busOut : drvOe ? drv : ~lastBus;
  assign sharedPins = x16 ? serialBits : addrPins;
  switch_host_port u_dut (
    .clk(clk), .resetn(resetn), .bus_style_pin(busStyle),
    .sepStrobeStyle(sepStyle), .chipSelectN(csN),
    .bus_strobe_or_read_strobe_n(strobe), .rwOrWriteN(rw),
    .address_latch_strobe(ale), .hostBusIn(busIn), .hostBusOut(busOut),
    .hostBusOe(busOe), .transfer_ack_n(ackN), .transferAckOe(ackOe),
    .sharedPins(sharedPins), .sixteenByEight(x16), .speedFast(fast),
    .serialClk(sclk), .frame_sync_in(frame),
    .serialExtraIn(serialExtraIn), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .frameStart(frameStart), .frameGci(frameGci),
    .clockMismatch(clockMismatch), .serialOutEnable(serialOutEnable)
  );
  host_cpu_model u_cpu (
    .clk(clk), .ackOe(ackOe), .devOe(busOe), .busIn(busIn), .csN(csN),
    .strobe(strobe), .rw(rw), .ale(ale), .drv(drv), .drvOe(drvOe),
    .addrPins(addrPins)
  );
  always @(posedge clk) begin
    lastBus <= busIn;
    if (regWrite) begin
      wrCnt <= wrCnt + 1;
      lastWa <= regAddr;
      lastWd <= regWdata;
    end
    if (regRead) begin
      rdCnt <= rdCnt + 1;
      lastRa <= regAddr;
    end
    if (frameStart) frames <= frames + 1;
  end
  task automatic chk(input string what, input logic [7:0] exp, got);
    samplesChecked++;
    if (got !== exp) begin
      errCount++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic giveVerdict;
    $display("checks %0d errors %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic t_reset;
    chk("oe in reset", 8'h00, 8'(serialOutEnable));
    chk("ack in reset", 8'h00, 8'(ackOe));
    resetn = 1'h1;
    repeat (2) @(negedge clk);
    chk("oe after reset", 8'h01, 8'(serialOutEnable));
  endtask
  task automatic t_nonmux;
    regRdata = 8'hA3;
    u_cpu.xfer(1'h0, 1'h0, 1'h0, 1'h1, 8'h2A, 8'h5C, rv, ok, oe);
    chk("write count", 8'h01, 8'(wrCnt));
    chk("write addr", 8'h2A, lastWa);
    chk("write data", 8'h5C, lastWd);
    chk("write ack", 8'h01, 8'(ok));
    chk("write bus oe", 8'h00, 8'(oe));
    u_cpu.xfer(1'h0, 1'h0, 1'h1, 1'h1, 8'h15, 8'h00, rv, ok, oe);
    chk("read count", 8'h01, 8'(rdCnt));
    chk("read addr", 8'h15, lastRa);
    chk("read data", 8'hA3, rv);
    chk("read bus oe", 8'h01, 8'(oe));
    chk("ack level", 8'h00, 8'(ackN));
  endtask
  task automatic t_nocs;
    u_cpu.xfer(1'h0, 1'h0, 1'h0, 1'h0, 8'h0F, 8'h77, rv, ok, oe);
    chk("unselected write", 8'h01, 8'(wrCnt));
    u_cpu.xfer(1'h0, 1'h0, 1'h1, 1'h0, 8'h0F, 8'h00, rv, ok, oe);
    chk("unselected read", 8'h01, 8'(rdCnt));
    chk("unselected ack", 8'h00, 8'(ok));
    chk("unselected oe", 8'h00, 8'(oe));
  endtask
  task automatic t_mux;
    busStyle = 1'h1;
    u_cpu.xfer(1'h1, 1'h0, 1'h0, 1'h1, 8'hC7, 8'h3E, rv, ok, oe);
    chk("mux addr", 8'hC7, lastWa);
    chk("mux data", 8'h3E, lastWd);
    sepStyle = 1'h1;
    regRdata = 8'h6D;
    u_cpu.xfer(1'h1, 1'h1, 1'h1, 1'h1, 8'h9B, 8'h00, rv, ok, oe);
    chk("sep read addr", 8'h9B, lastRa);
    chk("sep read data", 8'h6D, rv);
    chk("sep read oe", 8'h01, 8'(oe));
    u_cpu.xfer(1'h1, 1'h1, 1'h0, 1'h1, 8'h41, 8'hE2, rv, ok, oe);
    chk("sep write addr", 8'h41, lastWa);
    chk("sep write data", 8'hE2, lastWd);
    chk("sep write oe", 8'h00, 8'(oe));
    // acknowledge stands only until the cycle after the strobe drops
    @(negedge clk);
    chk("ack released", 8'h00, 8'(ackOe));
  endtask
  task automatic t_serial;
    x16 = 1'h1;
    serialBits = 6'h2D;
    repeat (3) @(negedge clk);
    chk("extra inputs", 8'h2D, 8'(serialExtraIn));
    x16 = 1'h0;
    repeat (3) @(negedge clk);
    chk("extra inputs off", 8'h00, 8'(serialExtraIn));
  endtask
  // long idle first, so only the short pulse can count as a frame
  task automatic pulse(input logic lvl);
    repeat (100) @(negedge clk);
    frame = !lvl;
    repeat (100) @(negedge clk);
    frame = lvl;
    repeat (10) @(negedge clk);
    frame = !lvl;
    repeat (5) @(negedge clk);
  endtask
  task automatic run_sclk(input int half);
    repeat (20) begin
      repeat (half) @(negedge clk);
      sclk = ~sclk;
    end
  endtask
  task automatic t_timing;
    pulse(1'h1);
    chk("frame count", 8'h01, 8'(frames));
    chk("gci format", 8'h01, 8'(frameGci));
    pulse(1'h0);
    chk("frame count", 8'h02, 8'(frames));
    chk("other format", 8'h00, 8'(frameGci));
    run_sclk(7);
    chk("fast on slow", 8'h01, 8'(clockMismatch));
    run_sclk(15);
    chk("slow on slow", 8'h00, 8'(clockMismatch));
    fast = 1'h1;
    run_sclk(15);
    chk("slow on fast", 8'h01, 8'(clockMismatch));
  endtask
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  initial begin
    {resetn, busStyle, sepStyle, x16, fast, sclk, frame} = 7'h00;
    regRdata = 8'h00;
    serialBits = 6'h00;
    lastBus = 8'h00;
    repeat (3) @(negedge clk);
    t_reset;
    t_nonmux;
    t_nocs;
    t_mux;
    t_serial;
    t_timing;
    giveVerdict;
  end
  // all scenarios need about 1200 cycles
  initial begin
    repeat (20000) @(posedge clk);
    errCount++;
    giveVerdict;
  end
endmodule
`default_nettype wire
